// File: include/wmon_params.svh
`ifndef WMON_PARAMS_SVH
`define WMON_PARAMS_SVH
`define WM_PTR_RESULT 3'h0
`define WM_PTR_STATUS 3'h1
`define WM_PTR_CONFIG 3'h2
`define WM_PTR_LOWER 3'h3
`define WM_PTR_UPPER 3'h4
`define WM_PTR_MARGIN 3'h5
`define WM_PTR_MIN 3'h6
`define WM_PTR_MAX 3'h7
`define WM_CFG_SEL_HI 7
`define WM_CFG_SEL_LO 5
`define WM_CFG_HOLD 4
`define WM_CFG_FLAG_EN 3
`define WM_CFG_PIN_EN 2
`define WM_CFG_POL 0
`define WM_CFG_WMASK 8'hFD
`define WM_ST_UNDER 0
`define WM_ST_OVER 1
`define WM_UPPER_RST 12'hFFF
`define WM_MIN_RST 12'hFFF
`define WM_DEV_ADDR 7'h2A
`define WM_CLK_NS 50
`define WM_CONV_TIME_NS 1000
`define WM_CONV_CYC ((`WM_CONV_TIME_NS + `WM_CLK_NS - 1) / `WM_CLK_NS)
`define WM_INT_SHIFT 4
`define WM_SCL_PERIOD_NS 2000
`define WM_SCL_QTR_CYC ((`WM_SCL_PERIOD_NS / 4) / `WM_CLK_NS)
`define WM_A_CMD 8'h00
`define WM_A_WDATA 8'h04
`define WM_A_STATUS 8'h08
`define WM_A_RDATA 8'h0C
`define WM_CMD_GO 0
`define WM_CMD_RD 1
`define WM_CMD_TWO 2
`define WM_CMD_PTR_LO 8
`define WM_CMD_PTR_HI 10
`define WM_STS_BUSY 0
`define WM_STS_NACK 1
`endif

// File: include/wmon_pkg.sv
package wmon_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_WDATA, D_RDATA, D_ACK, D_MACK} dev_phase_e;
  typedef enum logic [2:0] {OP_START, OP_TX, OP_RX_ACK, OP_RX_NACK, OP_STOP} link_op_e;
  typedef enum logic {H_IDLE, H_RUN} host_phase_e;
  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } sync_state_s;
  typedef struct packed {
    dev_phase_e ph;
    dev_phase_e ret;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] hold_b;
    logic hi_b;
    logic mnack;
    logic sda_rel;
    logic scl_p;
    logic sda_p;
    logic [2:0] ptr;
    logic [7:0] cfg;
    logic [11:0] lower_threshold;
    logic [11:0] upper_threshold;
    logic [11:0] clear_margin;
    logic [11:0] running_minimum;
    logic [11:0] running_maximum;
    logic [11:0] result;
    logic over;
    logic under;
    logic [23:0] tmr;
    logic conv_start;
    logic alert_lvl;
    logic alert_oe_n;
  } dev_state_s;
  typedef struct packed {
    link_op_e op;
    logic [7:0] b;
  } op_s;
  typedef struct packed {
    host_phase_e ph;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rd;
    logic two;
    logic [2:0] ptr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic nack;
    logic abort;
    logic [2:0] step;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic scl_oe_n;
    logic sda_oe_n;
  } host_state_s;
endpackage

// File: include/wmon_if.sv
interface wmon_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic scl;
  logic sda;
  // open-drain wires with pull-up
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  modport host (output scl_o, output scl_oe_n, output sda_h_o, output sda_h_oe_n, input sda);
  modport dev (output sda_d_o, output sda_d_oe_n, input scl, input sda);
endinterface

// File: rtl/wmon_sync.sv
module wmon_sync (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic d, // asynchronous level
  output logic q // filtered level
);
  wmon_pkg::sync_state_s s_ff;
  wmon_pkg::sync_state_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.f1 = d;
    nxt_s.f2 = s_ff.f1;
    nxt_s.f3 = s_ff.f2;
    if (s_ff.f2 == s_ff.f3)
    begin
      nxt_s.q = s_ff.f2;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_ff <= '1;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.q;
endmodule // wmon_sync

// File: rtl/wmon_device.sv
`include "wmon_params.svh"
// Function
// - zero selector disables auto mode; reset zero
// - non-zero selector starts periodic conversions
// - codes 1..7 give period times 32..2048
// - latch off: flags self-clear past margin
// - latch on: flags clear only by write-one
// - config bit 3 gates result bit 15
// - config bit 2 enables alert pin drive
// - config bit 0 selects alert active level
// - config bit 1 reserved, reads zero
// - result below lower threshold sets under flag
// - result above upper threshold sets over flag; reset FFF
// - clearing needs return inside by more than margin
// - auto mode: minimum replaced by lower result
// - minimum resets FFF; writing FFF restarts it
// - auto mode: maximum replaced by higher result
// - software writes zero to restart maximum
// - min/max update only in auto mode
// - 12-bit registers read upper nibble zero, except result bit 15
// - writing one to a flag clears it
// - result bit 15 is or of flags when enabled
module wmon_device #(
  parameter int CONV_CYCLES = `WM_CONV_CYC // single_conversion_time in clock cycles
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic ce, // clock enable
  wmon_if.dev link, // two-wire link
  input wire logic conv_done, // one-cycle pulse, conv_data valid
  input wire logic [11:0] conv_data, // conversion result
  output logic conv_start, // one-cycle pulse, start a conversion
  output logic alert_o, // alert pin level
  output logic alert_oe_n // alert pin enable, low drives
);
  wmon_pkg::dev_state_s s_ff;
  wmon_pkg::dev_state_s nxt_s;
  logic scl_q;
  logic sda_q;
  logic scl_r;
  logic scl_f;
  logic st_cond;
  logic sp_cond;
  logic auto_on;
  logic load;
  logic wr;
  logic [15:0] wdat;
  logic [15:0] rword;
  logic [1:0] wclr;
  logic set_o;
  logic set_u;
  logic clr_o;
  logic clr_u;
  logic act;

  function automatic logic [23:0] interval(input logic [2:0] sel);
    interval = 24'(CONV_CYCLES) << ({1'b0, sel} + 4'(`WM_INT_SHIFT));
  endfunction

  function automatic logic is8(input logic [2:0] p);
    is8 = (p == `WM_PTR_STATUS) || (p == `WM_PTR_CONFIG);
  endfunction

  function automatic logic [15:0] pad12(input logic [11:0] v);
    pad12 = {4'h0, v};
  endfunction

  wmon_sync u_scl (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .d(link.scl), .q(scl_q));
  wmon_sync u_sda (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .d(link.sda), .q(sda_q));

  assign scl_r = scl_q & ~s_ff.scl_p;
  assign scl_f = ~scl_q & s_ff.scl_p;
  assign st_cond = scl_q & s_ff.scl_p & s_ff.sda_p & ~sda_q;
  assign sp_cond = scl_q & s_ff.scl_p & ~s_ff.sda_p & sda_q;
  assign auto_on = s_ff.cfg[`WM_CFG_SEL_HI:`WM_CFG_SEL_LO] != 3'h0;

  always_comb
  begin
    // read word; 8-bit registers repeat in both bytes
    unique case (s_ff.ptr)
      `WM_PTR_RESULT: rword = {s_ff.cfg[`WM_CFG_FLAG_EN] & (s_ff.over | s_ff.under), 3'h0, s_ff.result};
      `WM_PTR_STATUS: rword = {2{6'h00, s_ff.over, s_ff.under}};
      `WM_PTR_CONFIG: rword = {2{s_ff.cfg & `WM_CFG_WMASK}};
      `WM_PTR_LOWER: rword = pad12(s_ff.lower_threshold);
      `WM_PTR_UPPER: rword = pad12(s_ff.upper_threshold);
      `WM_PTR_MARGIN: rword = pad12(s_ff.clear_margin);
      `WM_PTR_MIN: rword = pad12(s_ff.running_minimum);
      `WM_PTR_MAX: rword = pad12(s_ff.running_maximum);
    endcase
  end

  always_comb
  begin
    nxt_s = s_ff;
    load = 1'b0;
    wr = 1'b0;
    wdat = 16'h0000;
    wclr = 2'b00;
    nxt_s.scl_p = scl_q;
    nxt_s.sda_p = sda_q;
    nxt_s.conv_start = 1'b0;
    if (st_cond)
    begin
      nxt_s.ph = wmon_pkg::D_ADDR;
      nxt_s.bitn = 4'h0;
      nxt_s.sda_rel = 1'b1;
    end
    else if (sp_cond)
    begin
      nxt_s.ph = wmon_pkg::D_IDLE;
      nxt_s.sda_rel = 1'b1;
    end
    else if (scl_r)
    begin
      if (s_ff.ph inside {wmon_pkg::D_ADDR, wmon_pkg::D_PTR, wmon_pkg::D_WDATA})
      begin
        nxt_s.sh = {s_ff.sh[6:0], sda_q};
        nxt_s.bitn = s_ff.bitn + 4'h1;
      end
      else if (s_ff.ph == wmon_pkg::D_RDATA)
      begin
        nxt_s.bitn = s_ff.bitn + 4'h1;
      end
      else if (s_ff.ph == wmon_pkg::D_MACK)
      begin
        nxt_s.mnack = sda_q;
      end
    end
    else if (scl_f)
    begin
      unique case (s_ff.ph)
        wmon_pkg::D_IDLE:
        begin
        end
        wmon_pkg::D_ADDR:
        if (s_ff.bitn == 4'h8)
        begin
          nxt_s.hi_b = 1'b1;
          if (s_ff.sh[7:1] == `WM_DEV_ADDR)
          begin
            nxt_s.sda_rel = 1'b0;
            nxt_s.ph = wmon_pkg::D_ACK;
            nxt_s.ret = s_ff.sh[0] ? wmon_pkg::D_RDATA : wmon_pkg::D_PTR;
          end
          else
          begin
            nxt_s.ph = wmon_pkg::D_IDLE;
          end
        end
        wmon_pkg::D_PTR:
        if (s_ff.bitn == 4'h8)
        begin
          nxt_s.ptr = s_ff.sh[2:0];
          nxt_s.sda_rel = 1'b0;
          nxt_s.ph = wmon_pkg::D_ACK;
          nxt_s.ret = wmon_pkg::D_WDATA;
        end
        wmon_pkg::D_WDATA:
        if (s_ff.bitn == 4'h8)
        begin
          nxt_s.sda_rel = 1'b0;
          nxt_s.ph = wmon_pkg::D_ACK;
          nxt_s.ret = wmon_pkg::D_WDATA;
          if (is8(s_ff.ptr) || !s_ff.hi_b)
          begin
            wr = 1'b1;
            wdat = is8(s_ff.ptr) ? {8'h00, s_ff.sh} : {s_ff.hold_b, s_ff.sh};
            nxt_s.hi_b = 1'b1;
          end
          else
          begin
            nxt_s.hold_b = s_ff.sh;
            nxt_s.hi_b = 1'b0;
          end
        end
        wmon_pkg::D_ACK:
        begin
          nxt_s.sda_rel = 1'b1;
          nxt_s.bitn = 4'h0;
          nxt_s.ph = s_ff.ret;
          load = s_ff.ret == wmon_pkg::D_RDATA;
        end
        wmon_pkg::D_RDATA:
        if (s_ff.bitn == 4'h8)
        begin
          nxt_s.sda_rel = 1'b1;
          nxt_s.ph = wmon_pkg::D_MACK;
        end
        else
        begin
          nxt_s.sh = {s_ff.sh[6:0], 1'b0};
          nxt_s.sda_rel = s_ff.sh[6];
        end
        wmon_pkg::D_MACK:
        if (s_ff.mnack)
        begin
          nxt_s.ph = wmon_pkg::D_IDLE;
        end
        else
        begin
          load = 1'b1;
          nxt_s.bitn = 4'h0;
          nxt_s.ph = wmon_pkg::D_RDATA;
        end
      endcase
    end
    if (load)
    begin
      // word captured at its high byte so both bytes match
      if (s_ff.hi_b)
      begin
        nxt_s.sh = rword[15:8];
        nxt_s.hold_b = rword[7:0];
        if (s_ff.ptr == `WM_PTR_RESULT && !auto_on)
        begin
          nxt_s.conv_start = 1'b1;
        end
      end
      else
      begin
        nxt_s.sh = s_ff.hold_b;
      end
      nxt_s.hi_b = ~s_ff.hi_b;
      nxt_s.sda_rel = nxt_s.sh[7];
    end
    if (wr)
    begin
      unique case (s_ff.ptr)
        `WM_PTR_RESULT:
        begin
        end
        `WM_PTR_STATUS: wclr = wdat[1:0];
        `WM_PTR_CONFIG: nxt_s.cfg = wdat[7:0] & `WM_CFG_WMASK;
        `WM_PTR_LOWER: nxt_s.lower_threshold = wdat[11:0];
        `WM_PTR_UPPER: nxt_s.upper_threshold = wdat[11:0];
        `WM_PTR_MARGIN: nxt_s.clear_margin = wdat[11:0];
        `WM_PTR_MIN: nxt_s.running_minimum = wdat[11:0];
        `WM_PTR_MAX: nxt_s.running_maximum = wdat[11:0];
      endcase
    end
    if (!auto_on)
    begin
      nxt_s.tmr = 24'h000000;
    end
    else if (s_ff.tmr == 24'h000000)
    begin
      nxt_s.conv_start = 1'b1;
      nxt_s.tmr = interval(s_ff.cfg[`WM_CFG_SEL_HI:`WM_CFG_SEL_LO]) - 24'h000001;
    end
    else
    begin
      nxt_s.tmr = s_ff.tmr - 24'h000001;
    end
    set_o = conv_data > s_ff.upper_threshold;
    set_u = conv_data < s_ff.lower_threshold;
    clr_o = ({1'b0, conv_data} + {1'b0, s_ff.clear_margin}) < {1'b0, s_ff.upper_threshold};
    clr_u = {1'b0, conv_data} > ({1'b0, s_ff.lower_threshold} + {1'b0, s_ff.clear_margin});
    if (s_ff.cfg[`WM_CFG_HOLD])
    begin
      clr_o = 1'b0;
      clr_u = 1'b0;
    end
    // a new violation wins over any clear in the same cycle
    nxt_s.over = (s_ff.over & ~wclr[`WM_ST_OVER] & ~(conv_done & clr_o)) | (conv_done & set_o);
    nxt_s.under = (s_ff.under & ~wclr[`WM_ST_UNDER] & ~(conv_done & clr_u)) | (conv_done & set_u);
    if (conv_done)
    begin
      nxt_s.result = conv_data;
      if (auto_on)
      begin
        if (conv_data < nxt_s.running_minimum)
        begin
          nxt_s.running_minimum = conv_data;
        end
        if (conv_data > nxt_s.running_maximum)
        begin
          nxt_s.running_maximum = conv_data;
        end
      end
    end
    act = nxt_s.over | nxt_s.under;
    nxt_s.alert_lvl = nxt_s.cfg[`WM_CFG_POL] ? act : ~act;
    nxt_s.alert_oe_n = ~nxt_s.cfg[`WM_CFG_PIN_EN];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
      s_ff.sda_rel <= 1'b1;
      s_ff.scl_p <= 1'b1;
      s_ff.sda_p <= 1'b1;
      s_ff.upper_threshold <= `WM_UPPER_RST;
      s_ff.running_minimum <= `WM_MIN_RST;
      s_ff.alert_lvl <= 1'b1;
      s_ff.alert_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign conv_start = s_ff.conv_start;
  assign alert_o = s_ff.alert_lvl;
  assign alert_oe_n = s_ff.alert_oe_n;
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe_n = s_ff.sda_rel;
endmodule // wmon_device

// File: rtl/wmon_host.sv
`include "wmon_params.svh"
module wmon_host (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic ce, // clock enable
  wmon_if.host link, // two-wire link
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error, unmapped address
);
  wmon_pkg::host_state_s s_ff;
  wmon_pkg::host_state_s nxt_s;
  wmon_pkg::op_s cur;
  logic sda_q;
  logic access;
  logic commit;
  logic busy;

  function automatic wmon_pkg::op_s step_op(input logic [2:0] st, input logic rd, input logic two,
                                            input logic [2:0] ptr, input logic [15:0] wd);
    step_op.op = wmon_pkg::OP_STOP;
    step_op.b = 8'h00;
    unique case (st)
      3'h0: step_op.op = wmon_pkg::OP_START;
      3'h1: step_op = '{wmon_pkg::OP_TX, {`WM_DEV_ADDR, 1'b0}};
      3'h2: step_op = '{wmon_pkg::OP_TX, {5'h00, ptr}};
      3'h3: step_op = rd ? wmon_pkg::op_s'{wmon_pkg::OP_START, 8'h00} : wmon_pkg::op_s'{wmon_pkg::OP_TX, wd[15:8]};
      3'h4: step_op = rd ? wmon_pkg::op_s'{wmon_pkg::OP_TX, {`WM_DEV_ADDR, 1'b1}}
                      : two ? wmon_pkg::op_s'{wmon_pkg::OP_TX, wd[7:0]} : step_op;
      3'h5: step_op.op = !rd ? wmon_pkg::OP_STOP : two ? wmon_pkg::OP_RX_ACK : wmon_pkg::OP_RX_NACK;
      3'h6: step_op.op = (rd && two) ? wmon_pkg::OP_RX_NACK : wmon_pkg::OP_STOP;
      3'h7: step_op.op = wmon_pkg::OP_STOP;
    endcase
  endfunction

  wmon_sync u_sda (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .d(link.sda), .q(sda_q));

  assign busy = s_ff.ph == wmon_pkg::H_RUN;
  assign access = psel & penable & ~s_ff.pready;
  assign commit = psel & penable & pwrite & s_ff.pready;

  always_comb
  begin
    nxt_s = s_ff;
    cur = step_op(s_ff.step, s_ff.rd, s_ff.two, s_ff.ptr, s_ff.wdata);
    if (s_ff.abort)
    begin
      cur.op = wmon_pkg::OP_STOP;
    end
    nxt_s.pready = access;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata = 32'h00000000;
    if (psel && penable)
    begin
      case (paddr)
        `WM_A_CMD:
        begin
          nxt_s.prdata = {21'h000000, s_ff.ptr, 5'h00, s_ff.two, s_ff.rd, 1'b0};
          if (commit && !busy)
          begin
            nxt_s.rd = pwdata[`WM_CMD_RD];
            nxt_s.two = pwdata[`WM_CMD_TWO];
            nxt_s.ptr = pwdata[`WM_CMD_PTR_HI:`WM_CMD_PTR_LO];
            if (pwdata[`WM_CMD_GO])
            begin
              nxt_s.ph = wmon_pkg::H_RUN;
              nxt_s.step = 3'h0;
              nxt_s.q = 2'h0;
              nxt_s.div = 8'h00;
              nxt_s.bitn = 4'h0;
              nxt_s.nack = 1'b0;
              nxt_s.abort = 1'b0;
              nxt_s.rdata = 16'h0000;
            end
          end
        end
        `WM_A_WDATA:
        begin
          nxt_s.prdata = {16'h0000, s_ff.wdata};
          if (commit && !busy)
          begin
            nxt_s.wdata = pwdata[15:0];
          end
        end
        `WM_A_STATUS: nxt_s.prdata = {30'h00000000, s_ff.nack, busy};
        `WM_A_RDATA: nxt_s.prdata = {16'h0000, s_ff.rdata};
        default: nxt_s.pslverr = 1'b1;
      endcase
      if (!access)
      begin
        // answer only in the first access cycle; writes land when pready is seen
        nxt_s.prdata = 32'h00000000;
        nxt_s.pslverr = 1'b0;
      end
    end
    if (busy)
    begin
      if (s_ff.div != 8'h00)
      begin
        nxt_s.div = s_ff.div - 8'h01;
      end
      else
      begin
        nxt_s.div = 8'(`WM_SCL_QTR_CYC - 1);
        nxt_s.q = s_ff.q + 2'h1;
        unique case (cur.op)
          wmon_pkg::OP_START:
          begin
            unique case (s_ff.q)
              2'h0: nxt_s.sda_oe_n = 1'b1;
              2'h1: nxt_s.scl_oe_n = 1'b1;
              2'h2: nxt_s.sda_oe_n = 1'b0;
              2'h3:
              begin
                nxt_s.scl_oe_n = 1'b0;
                nxt_s.step = s_ff.step + 3'h1;
              end
            endcase
          end
          wmon_pkg::OP_STOP:
          begin
            unique case (s_ff.q)
              2'h0: nxt_s.sda_oe_n = 1'b0;
              2'h1: nxt_s.scl_oe_n = 1'b1;
              2'h2: nxt_s.sda_oe_n = 1'b1;
              2'h3: nxt_s.ph = wmon_pkg::H_IDLE;
            endcase
          end
          wmon_pkg::OP_TX, wmon_pkg::OP_RX_ACK, wmon_pkg::OP_RX_NACK:
          begin
            unique case (s_ff.q)
              2'h0:
              begin
                if (s_ff.bitn == 4'h0 && cur.op == wmon_pkg::OP_TX)
                begin
                  nxt_s.sh = cur.b;
                end
                if (s_ff.bitn == 4'h8)
                begin
                  nxt_s.sda_oe_n = cur.op != wmon_pkg::OP_RX_ACK;
                end
                else
                begin
                  nxt_s.sda_oe_n = (cur.op == wmon_pkg::OP_TX) ? nxt_s.sh[7] : 1'b1;
                end
              end
              2'h1: nxt_s.scl_oe_n = 1'b1;
              2'h2:
              begin
                if (s_ff.bitn == 4'h8 && cur.op == wmon_pkg::OP_TX && sda_q)
                begin
                  nxt_s.nack = 1'b1;
                  nxt_s.abort = 1'b1;
                end
                else if (s_ff.bitn != 4'h8 && cur.op != wmon_pkg::OP_TX)
                begin
                  nxt_s.sh = {s_ff.sh[6:0], sda_q};
                end
              end
              2'h3:
              begin
                nxt_s.scl_oe_n = 1'b0;
                if (s_ff.bitn == 4'h8)
                begin
                  nxt_s.bitn = 4'h0;
                  nxt_s.step = s_ff.step + 3'h1;
                  if (cur.op != wmon_pkg::OP_TX)
                  begin
                    nxt_s.rdata = {s_ff.rdata[7:0], s_ff.sh};
                  end
                end
                else
                begin
                  nxt_s.bitn = s_ff.bitn + 4'h1;
                  if (cur.op == wmon_pkg::OP_TX)
                  begin
                    nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
      s_ff.scl_oe_n <= 1'b1;
      s_ff.sda_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = s_ff.scl_oe_n;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe_n = s_ff.sda_oe_n;
endmodule // wmon_host

// File: test/wmon_sva.sv
module wmon_sva (
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset
  input wire logic scl_o, // host scl
  input wire logic scl_oe_n, // host scl en
  input wire logic sda_h_o, // host sda
  input wire logic sda_h_oe_n, // host sda en
  input wire logic sda_d_o, // dev sda
  input wire logic sda_d_oe_n, // dev sda en
  input wire logic scl, // wire
  input wire logic sda, // wire
  input wire logic conv_start, // conv request
  input wire logic alert_o, // alert level
  input wire logic alert_oe_n // alert en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  rst_idle_a: assert property ($rose(reset_n) |-> sda_d_oe_n && scl_oe_n && sda_h_oe_n && alert_oe_n && !conv_start)
    else $error("outputs not idle after reset");
  open_drain_a: assert property (!scl_o && !sda_h_o && !sda_d_o)
    else $error("pin driven high");
  start_gap_a: assert property (conv_start |=> !conv_start [*8])
    else $error("conversion requests too close");
  sda_turn_a: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device sda moved with scl high");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low too short");
  scl_back_a: assert property ($fell(scl) |-> ##[1:30] scl)
    else $error("scl held low");
  dev_release_a: assert property ($fell(sda_d_oe_n) |-> ##[1:400] sda_d_oe_n)
    else $error("device holds sda");
  cover property (conv_start);
  cover property ($fell(sda_d_oe_n));
  cover property (!alert_oe_n && alert_o);
endmodule // wmon_sva

// File: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] m; logic [31:0] e;} note_s;
  logic clk_sys, reset_n, ce, psel, penable, pwrite, pready, pslverr;
  logic conv_done, conv_start, alert_o, alert_oe_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] conv_data;
  int mismatches, check_count;
  note_s q[$];
  note_s x;
  wmon_if bus();
  wmon_host i_wmon_host (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .link(bus), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  wmon_device #(.CONV_CYCLES(1)) i_wmon_device (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .link(bus), .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .alert_o(alert_o), .alert_oe_n(alert_oe_n));
  wmon_sva i_wmon_sva (.clk_sys(clk_sys), .reset_n(reset_n), .scl_o(bus.scl_o), .scl_oe_n(bus.scl_oe_n),
    .sda_h_o(bus.sda_h_o), .sda_h_oe_n(bus.sda_h_oe_n), .sda_d_o(bus.sda_d_o),
    .sda_d_oe_n(bus.sda_d_oe_n), .scl(bus.scl), .sda(bus.sda), .conv_start(conv_start),
    .alert_o(alert_o), .alert_oe_n(alert_oe_n));

  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; reads leave a note for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e, output logic [31:0] r, output logic er);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      q.push_back('{m, e});
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // two-byte link transfer through the host registers
  task automatic dev(input logic rd, input logic [2:0] p, input logic [15:0] v);
    logic [31:0] r;
    logic e;
    if (!rd)
      apb(1, 8'h04, {16'h0, v}, 0, 0, r, e);
    apb(1, 8'h00, {21'h0, p, 5'h0, 1'b1, rd, 1'b1}, 0, 0, r, e);
    do apb(0, 8'h08, 0, 0, 0, r, e); while (r[0] !== 1'b0);
    check("nack", 32'(r[1]), 0);
    if (rd)
      apb(0, 8'h0C, 0, 32'hFFFF, {16'h0, v}, r, e);
  endtask

  task automatic conv(input logic [11:0] d);
    @(posedge clk_sys);
    conv_done <= 1;
    conv_data <= d;
    @(posedge clk_sys);
    conv_done <= 0;
    @(posedge clk_sys);
  endtask

  task automatic count(input int span, output int n);
    n = 0;
    repeat (span)
    begin
      @(posedge clk_sys);
      n += int'(conv_start);
    end
  endtask

  always @(posedge clk_sys)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
    begin
      x = q.pop_front();
      if (x.m != 0)
        check("rdata", prdata & x.m, x.e & x.m);
    end
  end

  initial
  begin
    #4_500_000;
    mismatches++;
    report_and_stop;
  end

  initial
  begin
    logic [15:0] rv [1:7];
    logic [11:0] d, mn, mx;
    logic [31:0] r;
    logic e;
    int n;
    rv = '{16'h0, 16'h0, 16'h0, 16'h0FFF, 16'h0, 16'h0FFF, 16'h0};
    {psel, penable, pwrite, conv_done, reset_n} = 0;
    ce = 1;
    paddr = 0;
    pwdata = 0;
    conv_data = 0;
    mn = 12'hFFF;
    mx = 0;
    void'($urandom(32'hC460));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1;
    for (int p = 1; p < 8; p++)
      dev(1, 3'(p), rv[p]);
    dev(0, 3, 16'h0100);
    dev(0, 4, 16'h0800);
    dev(0, 5, 16'h0010);
    dev(0, 2, 16'h0D0D);
    dev(1, 2, 16'h0D0D);
    conv(12'h900);
    check("alert_o", 32'(alert_o), 1);
    check("alert_oe_n", 32'(alert_oe_n), 0);
    dev(1, 1, 16'h0202);
    dev(1, 0, 16'h8900);
    conv(12'h7F8);
    check("alert_o", 32'(alert_o), 1);
    conv(12'h7EF);
    check("alert_o", 32'(alert_o), 0);
    dev(0, 2, 16'h1414);
    conv(12'h0FF);
    check("alert_o", 32'(alert_o), 0);
    dev(1, 0, 16'h00FF);
    conv(12'h200);
    check("alert_o", 32'(alert_o), 0);
    dev(0, 1, 16'h0101);
    check("alert_o", 32'(alert_o), 1);
    dev(1, 6, 16'h0FFF);
    dev(1, 7, 16'h0000);
    dev(0, 2, 16'h2020);
    check("alert_oe_n", 32'(alert_oe_n), 1);
    count(320, n);
    check("starts", n, 10);
    @(posedge clk_sys iff conv_start);
    ce <= 0;
    count(320, n);
    check("frozen", n, 0);
    ce <= 1;
    dev(0, 2, 16'hE0E0);
    count(4096, n);
    check("starts", n, 2);
    repeat (6)
    begin
      d = 12'($urandom_range(4094, 1));
      conv(d);
      if (d < mn)
        mn = d;
      if (d > mx)
        mx = d;
    end
    dev(1, 6, {4'h0, mn});
    dev(1, 7, {4'h0, mx});
    dev(0, 7, 16'h0000);
    dev(0, 6, 16'h0FFF);
    conv(12'h005);
    dev(1, 7, 16'h0005);
    dev(1, 6, 16'h0005);
    dev(0, 2, 16'h0000);
    count(320, n);
    check("starts", n, 0);
    apb(0, 8'h10, 0, 0, 0, r, e);
    check("pslverr", 32'(e), 1);
    report_and_stop;
  end
endmodule // testbench
